/* common/patl_regs.vh */
/*
  Constants for the page attribute type lookup: type field layout, memory
  type encodings, reset values, feature bit position and bus offsets.
  Assumes it is included by bare name from design files.
*/
`ifndef PATL_REGS_VH
`define PATL_REGS_VH

// ----------------------------------------------------------------------
// Memory type encodings
// ----------------------------------------------------------------------
`define PATL_TYPE_UC 3'h0
`define PATL_TYPE_WC 3'h1
`define PATL_TYPE_WT 3'h4
`define PATL_TYPE_WP 3'h5
`define PATL_TYPE_WB 3'h6
`define PATL_TYPE_UCW 3'h7

// ----------------------------------------------------------------------
// Attribute register layout
// ----------------------------------------------------------------------
`define PATL_FIELD_W 8
`define PATL_TYPE_W 3
`define PATL_FIELD_SIX 3'h6
`define PATL_FIELD_SEVEN 3'h7
`define PATL_ATTR_RESET 64'h0007040600070406
`define PATL_FIELD_MASK 8'h07
`define PATL_FIELD_COUNT 8
`define PATL_HALF_FIELDS 4
`define PATL_INDEX_W 3
`define PATL_ATTR_W 64
`define PATL_WORD_W 32

// ----------------------------------------------------------------------
// Feature result register
// ----------------------------------------------------------------------
`define PATL_FEATURE_BIT 16
`define PATL_FEATURE_VALUE 32'h00010000

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PATL_OFF_ATTR_LO 8'h00
`define PATL_OFF_ATTR_HI 8'h04
`define PATL_OFF_FEATURE 8'h08
`define PATL_OFF_STATUS 8'h0c

// ----------------------------------------------------------------------
// Entry levels
// ----------------------------------------------------------------------
`define PATL_LVL_FINAL 2'h0
`define PATL_LVL_LARGE 2'h1
`define PATL_LVL_UPPER 2'h2

`endif

/* rtl/patl_index.v */
/*
  Forms the three-bit type field index from a translation entry's bits.
  Assumes the level code says which kind of entry mapped the access.
*/
`timescale 1ns/1ps
`include "patl_regs.vh"

module patl_index (
  input wire [1:0] level,
  input wire page_attribute_index,
  input wire page_cache_disable_bit,
  input wire page_write_through_bit,
  output wire [2:0] field_index
);

  // ----------------------------------------------------------------------
  // Index formation
  // ----------------------------------------------------------------------
  // Upper-level entries carry no attribute-index bit, so only the lowest
  // four fields can be reached from them.
  wire use_attr;
  assign use_attr = (level == `PATL_LVL_FINAL) ||
                    (level == `PATL_LVL_LARGE);
  assign field_index = {use_attr & page_attribute_index,
                        page_cache_disable_bit,
                        page_write_through_bit};

endmodule

/* rtl/patl_lookup.v */
/*
  Page attribute type lookup: holds the eight-field attribute register,
  reports support in the feature result word and types each translated
  access. Assumes a translation unit presents one request per cycle and a
  simple register port with read data one cycle after the read strobe.
*/
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "patl_regs.vh"

module patl_lookup (
  input wire clock,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire req_valid,
  input wire [1:0] req_level,
  input wire [51:0] req_phys_addr,
  input wire page_attribute_index,
  input wire page_cache_disable_bit,
  input wire page_write_through_bit,
  input wire range_write_combining,
  output reg acc_valid,
  output reg [51:0] acc_phys_addr,
  output reg [2:0] acc_type,
  output reg acc_table_fetch,
  output reg [31:0] feature_result_register
);

  // ----------------------------------------------------------------------
  // Attribute register storage
  // ----------------------------------------------------------------------
  // Each field is a byte lane so the register reads back in place, but
  // only the type bits are ever stored.
  reg [`PATL_FIELD_W-1:0] type_field [0:`PATL_FIELD_COUNT-1];
  reg [`PATL_INDEX_W-1:0] last_index;
  reg [`PATL_TYPE_W-1:0] chosen_type;
  reg [`PATL_TYPE_W-1:0] next_type;
  wire [`PATL_INDEX_W-1:0] field_index;
  wire write_low;
  wire write_high;
  wire from_upper;
  integer i;

  // The mechanism is built in, so support is reported unconditionally.
  localparam attr_supported = 1'b1;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // True when the bus address selects the given register offset.
  function offset_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      offset_hit = (addr == offset);
    end
  endfunction

  // Clears the bits of a byte lane that carry no type.
  function [`PATL_FIELD_W-1:0] keep_type;
    input [`PATL_FIELD_W-1:0] lane;
    begin
      keep_type = lane & `PATL_FIELD_MASK;
    end
  endfunction

  // Picks the reset value of one field out of the packed reset word.
  function [`PATL_FIELD_W-1:0] reset_field;
    input integer n;
    reg [`PATL_ATTR_W-1:0] shifted;
    begin
      shifted = `PATL_ATTR_RESET >> (n * `PATL_FIELD_W);
      reset_field = shifted[`PATL_FIELD_W-1:0];
    end
  endfunction

  // Builds the feature result word with only the support bit set.
  function [`PATL_WORD_W-1:0] feature_word;
    input supported;
    begin
      feature_word = {`PATL_WORD_W{1'b0}};
      feature_word[`PATL_FEATURE_BIT] = supported;
    end
  endfunction

  // Joins the eight fields into one word, field n in byte lane n.
  function [`PATL_ATTR_W-1:0] pack_fields;
    input dummy;
    integer k;
    begin
      pack_fields = {`PATL_ATTR_W{1'b0}};
      for (k = 0; k < `PATL_FIELD_COUNT; k = k + 1)
        pack_fields[k*`PATL_FIELD_W +: `PATL_FIELD_W] = type_field[k];
    end
  endfunction

  // Forms the read data word for one register offset.
  function [`PATL_WORD_W-1:0] read_word;
    input [7:0] addr;
    input [`PATL_INDEX_W-1:0] status;
    reg [`PATL_ATTR_W-1:0] joined;
    begin
      joined = pack_fields(1'b0);
      case (addr)
        `PATL_OFF_ATTR_LO:
          read_word = joined[`PATL_WORD_W-1:0];
        `PATL_OFF_ATTR_HI:
          read_word = joined[`PATL_ATTR_W-1:`PATL_WORD_W];
        `PATL_OFF_FEATURE:
          read_word = feature_word(attr_supported);
        `PATL_OFF_STATUS:
          read_word = {{(`PATL_WORD_W-`PATL_INDEX_W){1'b0}}, status};
        default:
          read_word = {`PATL_WORD_W{1'b0}};
      endcase
    end
  endfunction

  patl_index u_index (
    .level(req_level),
    .page_attribute_index(page_attribute_index),
    .page_cache_disable_bit(page_cache_disable_bit),
    .page_write_through_bit(page_write_through_bit),
    .field_index(field_index)
  );

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  assign write_low = reg_write && offset_hit(reg_addr, `PATL_OFF_ATTR_LO);
  assign write_high = reg_write && offset_hit(reg_addr, `PATL_OFF_ATTR_HI);
  assign from_upper = (req_level == `PATL_LVL_UPPER);

  // ----------------------------------------------------------------------
  // Type selection
  // ----------------------------------------------------------------------
  // The weak uncacheable type yields to write-combining from a range.
  always @*
  begin
    chosen_type = type_field[field_index][`PATL_TYPE_W-1:0];
    next_type = chosen_type;
    if ((chosen_type == `PATL_TYPE_UCW) && range_write_combining)
      next_type = `PATL_TYPE_WC;
  end

  // ----------------------------------------------------------------------
  // Field storage
  // ----------------------------------------------------------------------
  // A write lands at its strobe edge, so a read in the next cycle already
  // sees the new fields.
  always @(posedge clock)
  begin
    if (rst)
    begin
      for (i = 0; i < `PATL_FIELD_COUNT; i = i + 1)
        type_field[i] <= reset_field(i);
    end
    else
    begin
      if (write_low)
        for (i = 0; i < `PATL_HALF_FIELDS; i = i + 1)
          type_field[i] <=
            keep_type(reg_wdata[i*`PATL_FIELD_W +: `PATL_FIELD_W]);
      if (write_high)
        for (i = 0; i < `PATL_HALF_FIELDS; i = i + 1)
          type_field[i+`PATL_HALF_FIELDS] <=
            keep_type(reg_wdata[i*`PATL_FIELD_W +: `PATL_FIELD_W]);
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Read data stand only in the cycle after the strobe and are zero
  // otherwise, so a bus that ORs several slaves stays clean.
  always @(posedge clock)
  begin
    if (rst)
      reg_rdata <= {`PATL_WORD_W{1'b0}};
    else if (reg_read)
      reg_rdata <= read_word(reg_addr, last_index);
    else
      reg_rdata <= {`PATL_WORD_W{1'b0}};
  end

  // ----------------------------------------------------------------------
  // Access typing
  // ----------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (rst)
      acc_valid <= 1'b0;
    else
      acc_valid <= req_valid;
  end

  // Address and type hold until the next request replaces them.
  always @(posedge clock)
  begin
    if (rst)
    begin
      acc_phys_addr <= 52'h0;
      acc_type <= `PATL_TYPE_UC;
    end
    else if (req_valid)
    begin
      acc_phys_addr <= req_phys_addr;
      acc_type <= next_type;
    end
  end

  // An upper-level type types the next lower table fetch.
  always @(posedge clock)
  begin
    if (rst)
      acc_table_fetch <= 1'b0;
    else if (req_valid)
      acc_table_fetch <= from_upper;
  end

  always @(posedge clock)
  begin
    if (rst)
      last_index <= {`PATL_INDEX_W{1'b0}};
    else if (req_valid)
      last_index <= field_index;
  end

  always @(posedge clock)
  begin
    if (rst)
      feature_result_register <= {`PATL_WORD_W{1'b0}};
    else
      feature_result_register <= feature_word(attr_supported);
  end

endmodule

/* testbench/patl_lookup_monitor.sv */
/*
  Port checker for the attribute lookup.
  Assumes it is bound to the lookup top and that reset is synchronous.
*/
`timescale 1ns/1ps
`include "patl_regs.vh"
module patl_lookup_monitor (
  input wire clock,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  input wire req_valid,
  input wire [1:0] req_level,
  input wire range_write_combining,
  input wire [2:0] acc_type,
  input wire [51:0] req_phys_addr,
  input wire acc_valid,
  input wire [51:0] acc_phys_addr,
  input wire acc_table_fetch,
  input wire [31:0] feature_result_register
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_up;
    req_valid && req_level == `PATL_LVL_UPPER;
  endsequence
  sequence s_low;
    req_valid && req_level < 2'h2;
  endsequence
  property p_valid;
    req_valid |=> acc_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("acc lost");
  property p_idle;
    !req_valid |=> !acc_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("acc spurious");
  property p_addr;
    req_valid |=> acc_phys_addr == $past(req_phys_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("acc addr");
  property p_up;
    s_up |=> acc_table_fetch;
  endproperty
  a_up: assert property (p_up) else $error("fetch flag low");
  property p_low;
    s_low |=> !acc_table_fetch;
  endproperty
  a_low: assert property (p_low) else $error("fetch flag high");
  property p_feat;
    !rst |=> feature_result_register == `PATL_FEATURE_VALUE;
  endproperty
  a_feat: assert property (p_feat) else $error("feature word");
  property p_rd;
    reg_read && reg_addr == `PATL_OFF_FEATURE |=> reg_rdata[16];
  endproperty
  a_rd: assert property (p_rd) else $error("feature read");
  property p_rz;
    !reg_read |=> reg_rdata == 32'h0;
  endproperty
  a_rz: assert property (p_rz) else $error("rdata not idle");
  property p_wc;
    req_valid && range_write_combining |=> acc_type != `PATL_TYPE_UCW;
  endproperty
  a_wc: assert property (p_wc) else $error("weak type kept");
endmodule

/* testbench/tb_patl_lookup.sv */
/*
  Self-checking bench for the attribute lookup.
  Assumes the shared header is on the include path.
*/
`timescale 1ns/1ps
`include "patl_regs.vh"
module tb_patl_lookup;
  reg clock = 0, rst = 1, reg_write = 0, reg_read = 0, req_valid = 0;
  reg pa = 0, pc = 0, pw = 0, rwc = 0;
  reg [7:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0, w;
  reg [1:0] req_level = 0;
  reg [51:0] req_phys_addr = 0;
  wire [31:0] reg_rdata, feature_result_register;
  wire acc_valid, acc_table_fetch;
  wire [51:0] acc_phys_addr;
  wire [2:0] acc_type;
  integer n_errors = 0, num_checks = 0, seed = 1609, cyc = 0, i, k;
  reg [2:0] f [0:7];
  always #2 clock = ~clock;
  patl_lookup u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_level(req_level),
    .req_phys_addr(req_phys_addr), .page_attribute_index(pa),
    .page_cache_disable_bit(pc), .page_write_through_bit(pw),
    .range_write_combining(rwc), .acc_valid(acc_valid),
    .acc_phys_addr(acc_phys_addr), .acc_type(acc_type),
    .acc_table_fetch(acc_table_fetch),
    .feature_result_register(feature_result_register));
  task chk(input [63:0] got, input [63:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task close_out;
  begin
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  function [2:0] ex(input [1:0] l, input a, input c, input b, input r);
    reg [2:0] x;
  begin
    x = {a & ~l[1], c, b};
    ex = (r && f[x] == `PATL_TYPE_UCW) ? `PATL_TYPE_WC : f[x];
  end
  endfunction
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clock);
    reg_write <= 0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] e);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clock);
    reg_read <= 0;
    @(negedge clock);
    chk(reg_rdata, e);
  end
  endtask
  task ac(input [1:0] l, input a, input c, input b, input r);
  begin
    @(posedge clock);
    {req_level, pa, pc, pw, rwc} <= {l, a, c, b, r};
    req_phys_addr <= req_phys_addr + 52'h1001;
    req_valid <= 1;
    @(posedge clock);
    req_valid <= 0;
    @(negedge clock);
    chk(acc_type, ex(l, a, c, b, r));
    chk(acc_table_fetch, l == 2'h2);
    chk(acc_valid, 1'b1);
  end
  endtask
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  initial
  begin
    for (i = 0; i < 8; i = i + 1)
      f[i] = `PATL_ATTR_RESET >> (i * 8);
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk(feature_result_register, 32'h0);
    @(posedge clock);
    rst <= 0;
    @(posedge clock);
    @(negedge clock);
    chk(feature_result_register, `PATL_FEATURE_VALUE);
    chk(acc_valid, 1'b0);
    rd(`PATL_OFF_ATTR_LO, 32'h00070406);
    rd(`PATL_OFF_ATTR_HI, 32'h00070406);
    rd(`PATL_OFF_FEATURE, `PATL_FEATURE_VALUE);
    rd(8'h10, 32'h0);
    ac(2'h0, 1, 1, 0, 1);
    ac(2'h1, 1, 1, 1, 1);
    ac(2'h1, 1, 1, 0, 0);
    for (i = 0; i < 24; i = i + 1)
      ac(i % 3, i[5], i[4], i[3], 0);
    for (i = 0; i < 40; i = i + 1)
    begin
      w = $random(seed);
      wr({5'h0, w[0], 2'h0}, w);
      for (k = 0; k < 4; k = k + 1)
        f[{w[0], 2'h0} + k] = w[k * 8 +: 3];
      rd({5'h0, w[0], 2'h0}, w & 32'h07070707);
      ac(w[5:4] % 3, w[1], w[2], w[3], w[6]);
    end
    close_out;
  end
endmodule
bind patl_lookup patl_lookup_monitor u_mon (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .req_valid(req_valid), .req_level(req_level),
  .range_write_combining(range_write_combining), .acc_type(acc_type),
  .req_phys_addr(req_phys_addr), .acc_valid(acc_valid),
  .acc_phys_addr(acc_phys_addr), .acc_table_fetch(acc_table_fetch),
  .feature_result_register(feature_result_register));
